// >>> ggr_pkg.sv
// package for the gas gauge register bank: offsets, fields, command codes
// assumes the serial bit engine and the measurement engine live elsewhere
package ggr_pkg;

  // ----------------------------------------------------------------------
  // register offsets (seven-bit address space)
  // ----------------------------------------------------------------------
  localparam logic [6:0] ADDR_PRIMARY_STATUS = 7'h01;
  localparam logic [6:0] ADDR_TEMPERATURE = 7'h02;
  localparam logic [6:0] ADDR_AVAIL_CAP = 7'h03;
  localparam logic [6:0] ADDR_LEARNED_CAP = 7'h05;
  localparam logic [6:0] ADDR_SECONDARY_STATUS = 7'h06;
  localparam logic [6:0] ADDR_CAP_SET_PIN = 7'h07;
  localparam logic [6:0] ADDR_PROG_PIN = 7'h08;
  localparam logic [6:0] ADDR_VALID_CHARGE = 7'h09;
  localparam logic [6:0] ADDR_LED_TEST = 7'h0a;
  localparam logic [6:0] ADDR_FULL_TALLY = 7'h0b;
  localparam logic [6:0] ADDR_COMMAND = 7'h0c;
  localparam logic [6:0] ADDR_PROG_CAP = 7'h0f;
  localparam logic [6:0] ADDR_BATT_V_LO = 7'h10;
  localparam logic [6:0] ADDR_BATT_V_HI = 7'h11;
  localparam logic [6:0] ADDR_SENSE_V_LO = 7'h12;
  localparam logic [6:0] ADDR_SENSE_V_HI = 7'h13;
  localparam logic [6:0] ADDR_THERM_V_LO = 7'h14;
  localparam logic [6:0] ADDR_THERM_V_HI = 7'h15;

  // ----------------------------------------------------------------------
  // command byte and field positions
  // ----------------------------------------------------------------------
  localparam int CMD_WRITE_BIT = 7;
  localparam int LED_ENABLE_N_BIT = 0;
  localparam logic [7:0] LED_TEST_MASK = 8'h3f;

  // ----------------------------------------------------------------------
  // command word codes, counts and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] CMD_FULL_RESET = 8'h78;
  localparam logic [7:0] CMD_CAL_START = 8'h68;
  localparam logic [7:0] CMD_CAL_STOP = 8'h60;
  localparam logic [7:0] VALID_CHARGE_MAX = 8'hff;
  localparam logic [7:0] VALID_CHARGE_STALE = 8'h40;
  localparam logic [3:0] FULL_TALLY_STEP = 4'hf;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_LED_TEST = 8'h01;

  // ----------------------------------------------------------------------
  // serial transaction states and stored state
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    S_CMD = 3'b001,
    S_WDATA = 3'b010,
    S_RDATA = 3'b100
  } ggr_state_t;

  typedef struct packed {
    ggr_state_t st;
    logic [6:0] addr;
    logic [7:0] avail_cap;
    logic [7:0] learned_cap;
    logic [7:0] valid_charge;
    logic [7:0] led_test;
    logic [7:0] full_tally;
    logic [3:0] full_sub;
    logic [7:0] command;
    logic [7:0] prog_cap;
    logic [7:0] discharge_tally;
    logic full_reset_flag;
    logic learning_stale_flag;
    logic end_discharge_voltage_flag;
    logic offset_cal_done_flag;
    logic cal_active;
    logic was_full;
    logic [7:0] rd_data;
    logic rd_valid;
    logic [5:1] led_out;
    logic sense_select;
    logic cal_busy;
  } ggr_regs_t;

endpackage

// >>> ggr_reg_bank.sv
// register bank of the gas gauge: command decode, flags and command word
// assumes a serial engine hands over whole bytes (lsb first already undone)
// and that the measurement engine supplies live values and event pulses
// one clock; engine pulses last one cycle
//
// Functional notes
// - command top bit selects write or read
// - address is command byte low seven bits
// - writes to undefined addresses are dropped
// - bit7 primary: set charge, cleared discharge
// - bit6 primary: set on full reset
// - bit5 primary follows cell overvoltage
// - bit4 set reset/count>64, cleared on learn
// - bit3 primary: discharge qualifies for learning
// - bit1 latches end voltage until charge
// - bit0 set after offset calibration completes
// - temperature is signed whole degrees
// - available capacity register, compensated units
// - learned full capacity is full reference
// - secondary bits 6:4 hold discharge rate code
// - secondary bit0 shows rate overload
// - pin level registers hold supply fraction
// - led test enable low drives leds directly
// - full tally counts full events by sixteen
// - 0x78 resets capacities, counts and tallies
// - 0x68 starts calibration, sense and leds off
// - 0x60 ends calibration in progress
// - calibration auto starts on trickle, powerup, full
// - voltages as 16-bit pairs, high at odd
// - valid charge count saturates, clears on learn
// - data byte follows command, lsb first
module ggr_reg_bank
  import ggr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  // byte engine side
  input wire logic [7:0] rx_byte,
  input wire logic rx_valid,
  input wire logic tx_taken,
  // engine levels and pulses
  input wire logic charge_detected,
  input wire logic discharge_detected,
  input wire logic cell_over_voltage,
  input wire logic discharge_qualified,
  input wire logic below_end_voltage,
  input wire logic valid_charge,
  input wire logic learn_update,
  input wire logic [7:0] learn_value,
  input wire logic [7:0] avail_cap_update,
  input wire logic avail_cap_load,
  input wire logic [7:0] discharge_tally_in,
  input wire logic discharge_tally_load,
  input wire logic cal_success,
  input wire logic trickle_detected,
  // live values, never latched
  input wire logic [7:0] temperature,
  input wire logic [2:0] discharge_rate,
  input wire logic overload,
  input wire logic [7:0] cap_set_pin_level,
  input wire logic [7:0] prog_pin_level,
  input wire logic [15:0] battery_voltage,
  input wire logic [15:0] sense_voltage,
  input wire logic [15:0] thermistor_voltage,
  // display pattern and capacity strap
  input wire logic [5:1] capacity_leds,
  input wire logic [7:0] prog_cap_strap,
  // outputs, each a flip-flop
  output logic [7:0] tx_byte,
  output logic tx_valid,
  output logic [5:1] led,
  output logic sense_enable,
  output logic cal_running,
  output logic [7:0] available_capacity,
  output logic [7:0] learned_full_capacity,
  output logic [7:0] discharge_tally
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // true for every address that holds a defined register
  // gaps in the map fall to default;
  // only the write path asks
  function automatic logic addr_defined(input logic [6:0] a);
    unique case (a)
      ADDR_PRIMARY_STATUS, ADDR_TEMPERATURE, ADDR_AVAIL_CAP,
      ADDR_LEARNED_CAP, ADDR_SECONDARY_STATUS, ADDR_CAP_SET_PIN,
      ADDR_PROG_PIN, ADDR_VALID_CHARGE, ADDR_LED_TEST, ADDR_FULL_TALLY,
      ADDR_COMMAND, ADDR_PROG_CAP, ADDR_BATT_V_LO, ADDR_BATT_V_HI,
      ADDR_SENSE_V_LO, ADDR_SENSE_V_HI, ADDR_THERM_V_LO,
      ADDR_THERM_V_HI: addr_defined = 1'b1;
      default: addr_defined = 1'b0;
    endcase
  endfunction

  // saturating increment, shared by the charge count and the full tally
  // a plain add would wrap and lose counts
  function automatic logic [7:0] sat_inc(input logic [7:0] v);
    sat_inc = (v == VALID_CHARGE_MAX) ? v : v + 8'h01;
  endfunction

  // every flip-flop except boot, and its next value
  ggr_regs_t r;
  ggr_regs_t next_r;
  logic [7:0] primary_status_flags;
  logic [7:0] secondary_status_flags;
  logic [7:0] rd_mux;
  logic is_full;
  logic [6:0] rd_addr;

  // ----------------------------------------------------------------------
  // status views, built from live inputs and latched flags
  // ----------------------------------------------------------------------
  // live charge/overvoltage/qualify bits come from the engine as levels;
  // the charging level is held by the engine between charge and discharge
  always_comb begin
    primary_status_flags = {
      charge_detected & ~discharge_detected,
      r.full_reset_flag,
      cell_over_voltage,
      r.learning_stale_flag,
      discharge_qualified,
      1'b0,
      r.end_discharge_voltage_flag,
      r.offset_cal_done_flag
    };
    // secondary flags: live rate and overload
    // reserved bits tied low, no storage
    secondary_status_flags = {
      1'b0,
      discharge_rate,
      3'b000,
      overload
    };
  end

  // a new command's address is used in the
  // cycle it arrives, so the first reply fits
  assign rd_addr = (r.st == S_CMD && rx_valid) ? rx_byte[6:0] : r.addr;

  // read mux; undefined addresses read zero;
  // 16-bit pairs are not latched together, so
  // a carry may land between low and high reads
  always_comb begin
    unique case (rd_addr)
      ADDR_PRIMARY_STATUS: rd_mux = primary_status_flags;
      ADDR_TEMPERATURE: rd_mux = temperature;
      ADDR_AVAIL_CAP: rd_mux = r.avail_cap;
      ADDR_LEARNED_CAP: rd_mux = r.learned_cap;
      ADDR_SECONDARY_STATUS: rd_mux = secondary_status_flags;
      ADDR_CAP_SET_PIN: rd_mux = cap_set_pin_level;
      ADDR_PROG_PIN: rd_mux = prog_pin_level;
      ADDR_VALID_CHARGE: rd_mux = r.valid_charge;
      ADDR_LED_TEST: rd_mux = r.led_test;
      ADDR_FULL_TALLY: rd_mux = r.full_tally;
      ADDR_COMMAND: rd_mux = r.command;
      ADDR_PROG_CAP: rd_mux = r.prog_cap;
      ADDR_BATT_V_LO: rd_mux = battery_voltage[7:0];
      ADDR_BATT_V_HI: rd_mux = battery_voltage[15:8];
      ADDR_SENSE_V_LO: rd_mux = sense_voltage[7:0];
      ADDR_SENSE_V_HI: rd_mux = sense_voltage[15:8];
      ADDR_THERM_V_LO: rd_mux = thermistor_voltage[7:0];
      ADDR_THERM_V_HI: rd_mux = thermistor_voltage[15:8];
      default: rd_mux = RST_ZERO;
    endcase
  end

  // full: available matches learned
  assign is_full = (r.avail_cap == r.learned_cap);

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic wr;
    logic do_reset;
    logic cal_start;
    wr = 1'b0;
    do_reset = 1'b0;
    cal_start = 1'b0;
    // later assignments win on purpose
    next_r = r;
    // was_full: a full event counts once
    next_r.was_full = is_full;

    // serial byte sequencing: command then one data byte
    unique case (r.st)
      S_CMD: begin
        // write waits for data; read replies
        if (rx_valid) begin
          next_r.addr = rx_byte[6:0];
          if (rx_byte[CMD_WRITE_BIT]) begin
            next_r.st = S_WDATA;
          end else begin
            next_r.st = S_RDATA;
            next_r.rd_valid = 1'b1;
          end
        end
      end
      S_WDATA: begin
        // data lands now; a gap in the map
        // leaves all state as it was
        if (rx_valid) begin
          wr = addr_defined(r.addr);
          next_r.st = S_CMD;
        end
      end
      S_RDATA: begin
        // the reply stands until the bit engine has shifted it out
        // new bytes are ignored meanwhile;
        // the host waits for the take
        if (tx_taken) begin
          next_r.rd_valid = 1'b0;
          next_r.st = S_CMD;
        end
      end
      default: next_r.st = S_CMD;
    endcase
    // refreshed while pending, so a live
    // value is fresh when it is taken
    next_r.rd_data = rd_mux;

    // engine updates first; host writes below take priority over them, except a trickle or full start beats a stop
    // the bank only stores what it is given
    if (avail_cap_load) begin
      next_r.avail_cap = avail_cap_update;
    end
    if (discharge_tally_load) begin
      next_r.discharge_tally = discharge_tally_in;
    end
    if (valid_charge) begin
      next_r.valid_charge = sat_inc(r.valid_charge);
    end
    // judged after this cycle's step, so the
    // 65th charge sets it as it counts
    if (next_r.valid_charge > VALID_CHARGE_STALE) begin
      next_r.learning_stale_flag = 1'b1;
    end
    // a learn restarts the count and wins
    if (learn_update) begin
      next_r.learned_cap = learn_value;
      next_r.valid_charge = RST_ZERO;
      next_r.learning_stale_flag = 1'b0;
    end
    // end voltage latch; a new crossing wins over the clearing charge
    if (valid_charge) begin
      next_r.end_discharge_voltage_flag = 1'b0;
    end
    if (below_end_voltage) begin
      next_r.end_discharge_voltage_flag = 1'b1;
    end
    // full event counted on the rising match; tally moves every sixteen
    // the sub-count itself is not visible
    if (is_full && !r.was_full) begin
      next_r.full_sub = r.full_sub + 4'h1;
      if (r.full_sub == FULL_TALLY_STEP) begin
        next_r.full_tally = sat_inc(r.full_tally);
      end
      cal_start = 1'b1;
    end
    // trickle shares the start path with
    // the host's calibration command
    if (trickle_detected) begin
      cal_start = 1'b1;
    end

    // host register writes
    // read-only targets and reserved led
    // test bits drop the write silently
    if (wr) begin
      unique case (r.addr)
        ADDR_AVAIL_CAP: next_r.avail_cap = rx_byte;
        ADDR_LEARNED_CAP: next_r.learned_cap = rx_byte;
        ADDR_LED_TEST: next_r.led_test = rx_byte & LED_TEST_MASK;
        ADDR_FULL_TALLY: next_r.full_tally = rx_byte;
        ADDR_PROG_CAP: next_r.prog_cap = rx_byte;
        ADDR_COMMAND: begin
          // stored, so the host can read it back
          next_r.command = rx_byte;
          if (rx_byte == CMD_FULL_RESET) begin
            do_reset = 1'b1;
          end
          if (rx_byte == CMD_CAL_START) begin
            cal_start = 1'b1;
          end
          // a stop leaves the done flag alone
          if (rx_byte == CMD_CAL_STOP) begin
            next_r.cal_active = 1'b0;
          end
        end
        default: ; // read-only targets keep their value
      endcase
    end

    // applied last: beats this cycle's loads
    if (do_reset) begin
      next_r.avail_cap = RST_ZERO;
      next_r.valid_charge = RST_ZERO;
      next_r.full_tally = RST_ZERO;
      next_r.full_sub = 4'h0;
      next_r.discharge_tally = RST_ZERO;
      next_r.learned_cap = r.prog_cap;
      next_r.full_reset_flag = 1'b1;
      next_r.learning_stale_flag = 1'b1;
    end

    // calibration: success only counts while one is running
    // a start with a success keeps the run
    // going and leaves the done flag alone
    if (cal_start) begin
      next_r.cal_active = 1'b1;
    end else if (r.cal_active && cal_success) begin
      next_r.cal_active = 1'b0;
      next_r.offset_cal_done_flag = 1'b1;
    end

    // pin drive: calibration blanks leds and deselects the sense inputs
    // from next_r, so pins move with the
    // calibration state, not a cycle late
    if (next_r.cal_active) begin
      next_r.led_out = 5'h00;
    end else if (!next_r.led_test[LED_ENABLE_N_BIT]) begin
      next_r.led_out = next_r.led_test[5:1];
    end else begin
      next_r.led_out = capacity_leds;
    end
    next_r.sense_select = ~next_r.cal_active;
    next_r.cal_busy = next_r.cal_active;
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  // power-up acts as a full reset and starts an offset calibration; the
  // programmed capacity strap is taken on the first clock after release
  // was_full starts set: both capacities are
  // zero in reset, a false match to ignore
  // later strap changes wait for power-up;
  // a host write replaces the capacity
  logic boot;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      boot <= 1'b1;
      r <= '{st: S_CMD, led_test: RST_LED_TEST, full_reset_flag: 1'b1,
             learning_stale_flag: 1'b1, cal_active: 1'b1,
             was_full: 1'b1, default: '0};
    end else begin
      boot <= 1'b0;
      r <= next_r;
      if (boot) begin
        r.prog_cap <= prog_cap_strap;
        r.learned_cap <= prog_cap_strap;
      end
    end
  end

  // ----------------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ----------------------------------------------------------------------
  // field renames only, no logic between
  assign tx_byte = r.rd_data;
  assign tx_valid = r.rd_valid;
  assign led = r.led_out;
  assign sense_enable = r.sense_select;
  assign cal_running = r.cal_busy;
  assign available_capacity = r.avail_cap;
  assign learned_full_capacity = r.learned_cap;
  assign discharge_tally = r.discharge_tally;

endmodule

// >>> ggr_monitor.sv
// checker for the gas gauge register bank, top-level ports only
// assumes one clock domain and whole bytes from the serial engine
module ggr_monitor
  import ggr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] rx_byte,
  input wire logic rx_valid,
  input wire logic tx_taken,
  input wire logic learn_update,
  input wire logic [7:0] learn_value,
  input wire logic [7:0] avail_cap_update,
  input wire logic avail_cap_load,
  input wire logic [7:0] discharge_tally_in,
  input wire logic discharge_tally_load,
  input wire logic cal_success,
  input wire logic trickle_detected,
  input wire logic tx_valid,
  input wire logic [5:1] led,
  input wire logic sense_enable,
  input wire logic cal_running,
  input wire logic [7:0] available_capacity,
  input wire logic [7:0] learned_full_capacity,
  input wire logic [7:0] discharge_tally
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // ----
  // byte phase
  // ----
  logic want_data;
  // a data byte looks like a command, only the phase tells them apart
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      want_data <= 1'b0;
    end else if (rx_valid && !tx_valid) begin
      want_data <= !want_data && rx_byte[CMD_WRITE_BIT];
    end
  end
  // ----
  // properties
  // ----
  chk_read_reply: assert property (
    rx_valid && !tx_valid && !want_data && !rx_byte[CMD_WRITE_BIT]
    |=> tx_valid) else $error("read command got no reply");
  chk_write_quiet: assert property (
    rx_valid && !tx_valid && rx_byte[CMD_WRITE_BIT] |=> !tx_valid)
    else $error("write byte raised a reply");
  chk_reply_hold: assert property (
    tx_valid && !tx_taken |=> tx_valid) else $error("reply dropped early");
  chk_reply_drop: assert property (
    tx_valid && tx_taken |=> !tx_valid) else $error("reply not released");
  chk_cal_quiet: assert property (
    $past(cal_running) && cal_running |-> led == 5'h00 && !sense_enable)
    else $error("leds or sense active in calibration");
  chk_trickle_cal: assert property (
    trickle_detected |=> cal_running) else $error("trickle did not start cal");
  chk_success_end: assert property (
    cal_running && cal_success && !trickle_detected && !rx_valid &&
    !avail_cap_load && available_capacity != learned_full_capacity
    |=> !cal_running) else $error("calibration did not end");
  chk_avail_load: assert property (
    avail_cap_load && !rx_valid
    |=> available_capacity == $past(avail_cap_update))
    else $error("available capacity not loaded");
  chk_learn_load: assert property (
    learn_update && !rx_valid |=> learned_full_capacity == $past(learn_value))
    else $error("learned capacity not loaded");
  chk_tally_load: assert property (
    discharge_tally_load && !rx_valid
    |=> discharge_tally == $past(discharge_tally_in))
    else $error("discharge tally not loaded");
endmodule

bind ggr_reg_bank ggr_monitor ggr_monitor_i (.clk_sys(clk_sys), .rstn(rstn),
  .rx_byte(rx_byte), .rx_valid(rx_valid), .tx_taken(tx_taken),
  .learn_update(learn_update), .learn_value(learn_value),
  .avail_cap_update(avail_cap_update), .avail_cap_load(avail_cap_load),
  .discharge_tally_in(discharge_tally_in),
  .discharge_tally_load(discharge_tally_load), .cal_success(cal_success),
  .trickle_detected(trickle_detected), .tx_valid(tx_valid), .led(led),
  .sense_enable(sense_enable), .cal_running(cal_running),
  .available_capacity(available_capacity),
  .learned_full_capacity(learned_full_capacity),
  .discharge_tally(discharge_tally));

// >>> ggr_host_model.sv
// host side model: takes each read reply after a chosen wait
// assumes tx_valid is a level that holds until the take is seen
module ggr_host_model
  import ggr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic [3:0] delay,
  output logic tx_taken,
  output logic [7:0] reply,
  output int replies
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_cnt;
  // take request held across one full rising edge, then released
  always @(negedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tx_taken <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (tx_taken) begin
      tx_taken <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (tx_valid) begin
      if (wait_cnt == delay) tx_taken <= 1'b1;
      else wait_cnt <= wait_cnt + 4'h1;
    end
  end
  // the byte is only trusted at the edge where the take is seen
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      replies <= 0;
      reply <= 8'h00;
    end else if (tx_taken && tx_valid) begin
      reply <= tx_byte;
      replies <= replies + 1;
    end
  end
endmodule

// >>> testbench.sv
// self-checking bench for the gas gauge register bank
// assumes the host model takes replies while the bench plays the byte engine
module testbench
  import ggr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0, rstn = 1'b0, rx_valid, tx_taken, tx_valid, overload;
  logic charge_detected, discharge_detected, cell_over_voltage, cal_success;
  logic discharge_qualified, below_end_voltage, valid_charge, learn_update;
  logic avail_cap_load, discharge_tally_load, trickle_detected, sense_enable;
  logic cal_running;
  logic [2:0] discharge_rate;
  logic [3:0] host_delay;
  logic [5:1] capacity_leds, led;
  logic [7:0] rx_byte, learn_value, avail_cap_update, discharge_tally_in;
  logic [7:0] temperature, cap_set_pin_level, prog_pin_level, prog_cap_strap;
  logic [7:0] tx_byte, available_capacity, learned_full_capacity, reply;
  logic [7:0] discharge_tally;
  logic [15:0] battery_voltage, sense_voltage, thermistor_voltage;
  int replies, fail_count = 0, checks = 0, cycles = 0;
  ggr_reg_bank ggr_reg_bank_i (.*);
  ggr_host_model ggr_host_model_i (.clk_sys, .rstn, .tx_valid, .tx_byte,
    .delay(host_delay), .tx_taken, .reply, .replies);
  always #20 clk_sys = ~clk_sys;
  // hang guard, well above the two thousand or so cycles the run needs
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      close_out();
    end
  end
  // ----
  // tasks
  // ----
  task automatic close_out();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk_sys);
    s = 1'b1;
    @(negedge clk_sys);
    s = 1'b0;
  endtask
  task automatic send(input logic [7:0] b);
    @(negedge clk_sys);
    rx_byte = b;
    rx_valid = 1'b1;
    @(negedge clk_sys);
    rx_valid = 1'b0;
  endtask
  // settle two cycles so registered side effects are visible
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    send({1'b1, a});
    send(d);
    repeat (2) @(negedge clk_sys);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    int n;
    n = replies;
    send({1'b0, a});
    for (int i = 0; i < 40 && replies == n; i++) @(negedge clk_sys);
    if (replies == n) cmp(8'h00, 8'h01);
    repeat (2) @(negedge clk_sys);
    cmp(reply, exp);
  endtask
  // ----
  // sequence
  // ----
  initial begin
    {rx_byte, rx_valid, charge_detected, discharge_detected} = '0;
    {cell_over_voltage, discharge_qualified, below_end_voltage} = '0;
    {valid_charge, learn_update, learn_value, avail_cap_update} = '0;
    {avail_cap_load, discharge_tally_in, discharge_tally_load} = '0;
    {cal_success, trickle_detected, temperature, discharge_rate} = '0;
    {overload, cap_set_pin_level, prog_pin_level, battery_voltage} = '0;
    {sense_voltage, thermistor_voltage} = '0;
    host_delay = 4'h0;
    prog_cap_strap = 8'h64;
    capacity_leds = 5'h0b;
    repeat (8) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (2) @(negedge clk_sys);
    cmp(cal_running, 1'b1);
    rd(ADDR_LED_TEST, RST_LED_TEST);
    rd(ADDR_VALID_CHARGE, RST_ZERO);
    rd(ADDR_PRIMARY_STATUS, 8'h50);
    pulse(cal_success);
    cmp(cal_running, 1'b0);
    host_delay = 4'h3;
    // live values and flag inputs stepped through six combinations
    for (int i = 0; i < 6; i++) begin
      logic [3:0] f;
      logic [7:0] pe, se;
      f = 4'(i * 3);
      {discharge_qualified, cell_over_voltage} = f[3:2];
      {discharge_detected, charge_detected} = f[1:0];
      discharge_rate = 3'(i);
      overload = f[1];
      temperature = 8'hf6 - 8'(i);
      cap_set_pin_level = 8'h80 + 8'(i);
      prog_pin_level = 8'h40 ^ 8'(i);
      battery_voltage = 16'h1234 + 16'(i);
      sense_voltage = 16'h0a5c - 16'(i);
      thermistor_voltage = {8'(i), 8'h3c};
      // bits 6 and 4 stay set from reset, bit 0 from the calibration
      pe = {f[0] & ~f[1], 1'b1, f[2], 1'b1, f[3], 3'b001};
      se = {1'b0, 3'(i), 3'b000, f[1]};
      rd(ADDR_PRIMARY_STATUS, pe);
      rd(ADDR_SECONDARY_STATUS, se);
      rd(ADDR_TEMPERATURE, temperature);
      rd(ADDR_CAP_SET_PIN, cap_set_pin_level);
      rd(ADDR_PROG_PIN, prog_pin_level);
      rd(ADDR_BATT_V_LO, battery_voltage[7:0]);
      rd(ADDR_BATT_V_HI, battery_voltage[15:8]);
      rd(ADDR_SENSE_V_LO, sense_voltage[7:0]);
      rd(ADDR_SENSE_V_HI, sense_voltage[15:8]);
      rd(ADDR_THERM_V_LO, thermistor_voltage[7:0]);
      rd(ADDR_THERM_V_HI, thermistor_voltage[15:8]);
    end
    wr(ADDR_AVAIL_CAP, 8'h83);
    wr(7'h04, 8'h5a);
    rd(7'h04, RST_ZERO);
    rd(ADDR_AVAIL_CAP, 8'h83);
    wr(ADDR_PRIMARY_STATUS, 8'h00);
    rd(ADDR_PRIMARY_STATUS, 8'h79);
    wr(ADDR_LED_TEST, 8'h2a);
    cmp(led, 5'h15);
    wr(ADDR_LED_TEST, 8'hff);
    rd(ADDR_LED_TEST, LED_TEST_MASK);
    cmp(led, capacity_leds);
    learn_value = 8'h3c;
    pulse(learn_update);
    rd(ADDR_LEARNED_CAP, 8'h3c);
    pulse(below_end_voltage);
    rd(ADDR_PRIMARY_STATUS, 8'h6b);
    repeat (64) pulse(valid_charge);
    rd(ADDR_PRIMARY_STATUS, 8'h69);
    pulse(valid_charge);
    rd(ADDR_PRIMARY_STATUS, 8'h79);
    repeat (200) pulse(valid_charge);
    rd(ADDR_VALID_CHARGE, VALID_CHARGE_MAX);
    pulse(learn_update);
    rd(ADDR_VALID_CHARGE, RST_ZERO);
    avail_cap_update = 8'h21;
    pulse(avail_cap_load);
    discharge_tally_in = 8'h17;
    pulse(discharge_tally_load);
    wr(ADDR_FULL_TALLY, 8'h05);
    wr(ADDR_COMMAND, CMD_FULL_RESET);
    rd(ADDR_COMMAND, CMD_FULL_RESET);
    cmp(available_capacity | discharge_tally, RST_ZERO);
    cmp(learned_full_capacity, prog_cap_strap);
    rd(ADDR_FULL_TALLY, RST_ZERO);
    wr(ADDR_COMMAND, CMD_CAL_START);
    cmp({cal_running, sense_enable, led}, 8'h40);
    wr(ADDR_COMMAND, CMD_CAL_STOP);
    cmp(cal_running, 1'b0);
    // each match of available and learned starts calibration and counts
    for (int k = 0; k < 32; k++) begin
      wr(ADDR_AVAIL_CAP, prog_cap_strap);
      if (k == 0) cmp(cal_running, 1'b1);
      wr(ADDR_COMMAND, CMD_CAL_STOP);
      wr(ADDR_AVAIL_CAP, RST_ZERO);
    end
    rd(ADDR_FULL_TALLY, 8'h02);
    pulse(trickle_detected);
    cmp(cal_running, 1'b1);
    pulse(cal_success);
    close_out();
  end
endmodule
